// File: acquisition_run_controller.sv
// run control: range handling, housekeeping tick, errors, task flags
// assumes filter-logic inputs on the same clock; jumper pin is asynchronous
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "run_ctl_consts.svh"
module acquisition_run_controller #(
	parameter int TICK_CYCLES = `TICK_US * `CLK_MHZ
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	// avalon-mm slave
	input  wire logic [7:0]            address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [31:0]           writedata,
	output logic      [31:0]           readdata,
	output logic                       waitrequest,
	// pulse-filter logic
	input  wire logic                  out_of_range,
	input  wire logic                  range_high,
	input  wire logic                  is_reset,
	input  wire logic                  event_out,
	input  wire logic                  event_in,
	input  wire logic                  live,
	input  wire logic                  comm_error,
	input  wire logic                  trackcal_error,
	input  wire logic                  special_done,
	// board jumper, asynchronous
	input  wire logic                  offset_jumper,
	// to filter logic and DACs
	output run_ctl_pkg::task_ctl_t     task_ctl,
	output run_ctl_pkg::dac_out_t      dac,
	output logic                       hold_mid,
	output logic                       running,
	output logic                       special_start,
	output logic      [15:0]           special_code,
	// front panel
	output logic                       led_green,
	output logic                       led_red,
	output logic                       status_led_red
);
	localparam int HOLD_CYC = (`HOLD_UNIT_NS + `CLK_NS - 1) / `CLK_NS;

	function automatic logic test_ok(input logic [15:0] c);
		test_ok = (c <= 16'h0004) || c == 16'h0006 || c == 16'h0008
			|| (c >= 16'h000b && c <= 16'h0010);
	endfunction

	function automatic logic [1:0] preset_sel(input logic [15:0] t);
		preset_sel = (t == 16'h0001) ? 2'h2 : (t == 16'h0002) ? 2'h1
			: (t == 16'h0003) ? 2'h0 : 2'h3;
	endfunction

	run_ctl_pkg::run_state_t   state;
	run_ctl_pkg::range_state_t rstate;
	logic [15:0] task_flags;
	logic [15:0] error_code;
	logic [15:0] test_selector;
	logic        rc_mode;
	logic [15:0] reset_hold_interval;
	logic [15:0] slope_value;
	logic [15:0] slope_step_fraction;
	logic [15:0] yellow_threshold;
	logic [15:0] red_threshold;
	logic [15:0] preset_type;
	logic [31:0] preset_length;
	logic [15:0] drift_high_count;
	logic [15:0] drift_low_count;
	logic signed [15:0] balance;
	logic [31:0] cnt_raw [4];
	logic [31:0] cnt_vis [4];
	logic [3:0]  cnt_inc;
	logic        ack;
	logic [31:0] next_readdata;
	logic [15:0] tick_cnt;
	logic        tick;
	logic [2:0]  unit_cnt;
	logic [15:0] hold_left;
	logic [2:0]  jmp_sync;
	logic        jumper_offset;

	// bus decode; one wait state, write lands when waitrequest is low
	wire req      = read | write;
	wire wr_fire  = write & ack;
	wire [15:0] wd = writedata[15:0];
	wire wr_flags = wr_fire && address == `A_FLAGS;
	wire wr_err   = wr_fire && address == `A_ERROR;
	wire wr_test  = wr_fire && address == `A_TEST;
	wire wr_ctrl  = wr_fire && address == `A_CTRL;
	wire wr_sdac  = wr_fire && address == `A_SDAC;
	wire wr_odac  = wr_fire && address == `A_ODAC;
	assign waitrequest = req & ~ack;

	// run control decode
	wire idle_now   = state == run_ctl_pkg::st_idle;
	wire err_now    = state == run_ctl_pkg::st_error;
	wire start_req  = wr_ctrl & wd[0] & idle_now;
	wire stop_req   = wr_ctrl & wd[1];
	wire setup_bad  = ~rc_mode & jumper_offset;
	wire special    = task_flags[8];
	wire start_norm = start_req & ~special & ~setup_bad;
	wire start_spec = start_req & special & ~setup_bad & test_ok(test_selector);
	wire [15:0] err_new = comm_error ? `ERR_COMM
		: (start_req & setup_bad) ? `ERR_SETUP
		: trackcal_error ? `ERR_TCAL : `ERR_NONE;
	wire err_fire   = err_new != `ERR_NONE && !err_now;
	wire err_clear  = wr_err && wd == `ERR_NONE && err_new == `ERR_NONE;
	wire [31:0] psel = cnt_raw[preset_sel(preset_type)];
	wire preset_hit = preset_type != 16'h0000 && psel > preset_length;

	// range handling decode
	wire asc_ok     = !err_now && rstate == run_ctl_pkg::rg_track;
	wire oor_reset  = asc_ok & out_of_range & is_reset & ~rc_mode;
	wire oor_drift  = asc_ok & out_of_range & ~oor_reset;
	wire hold_done  = hold_left == 16'h0000;
	wire [31:0] slope_prod = slope_value * slope_step_fraction;
	wire [15:0] slope_step = slope_prod[31:16];
	wire trim_ok    = task_flags[1] & tick;

	// output/input ratio against thresholds, both in 1.15 fixed point
	wire [47:0] out_sc  = {1'h0, cnt_raw[0], 15'h0000};
	wire [47:0] yel_lim = yellow_threshold * cnt_raw[3];
	wire [47:0] red_lim = red_threshold * cnt_raw[3];
	wire ratio_green = cnt_raw[3] == 32'h0 || out_sc > yel_lim;
	wire ratio_red   = !ratio_green && out_sc < red_lim;

	assign cnt_inc = {running & event_in, running, running & live,
		running & event_out};
	assign running       = state == run_ctl_pkg::st_run;
	assign status_led_red = err_now;
	assign hold_mid      = rstate == run_ctl_pkg::rg_hold;
	assign task_ctl = '{
		rate_track:    task_flags[1],
		fir_average:   task_flags[2],
		base_acquire:  task_flags[3],
		thr_adjust:    task_flags[4],
		shift_correct: task_flags[5],
		resid_correct: task_flags[6],
		hist_freeze:   task_flags[7],
		hist_delta:    task_flags[9],
		base_cut:      task_flags[10]
	};

	always_comb
	begin
		next_readdata = 32'h0000_0000;
		unique case (address)
			`A_FLAGS: next_readdata = {16'h0, task_flags};
			`A_ERROR: next_readdata = {16'h0, error_code};
			`A_TEST:  next_readdata = {16'h0, test_selector};
			`A_CTRL:  next_readdata = {29'h0, rc_mode, 2'h0};
			`A_STAT:  next_readdata = {27'h0, test_ok(test_selector), hold_mid,
				err_now, state == run_ctl_pkg::st_special, running};
			`A_HOLD:  next_readdata = {16'h0, reset_hold_interval};
			`A_SLOPEV: next_readdata = {16'h0, slope_value};
			`A_SFRAC: next_readdata = {16'h0, slope_step_fraction};
			`A_YEL:   next_readdata = {16'h0, yellow_threshold};
			`A_RED:   next_readdata = {16'h0, red_threshold};
			`A_PTYPE: next_readdata = {16'h0, preset_type};
			`A_PLEN:  next_readdata = preset_length;
			`A_TDAC:  next_readdata = {16'h0, dac.tracking_dac};
			`A_SDAC:  next_readdata = {16'h0, dac.slope_dac_a};
			`A_ODAC:  next_readdata = {16'h0, dac.offset_dac_b};
			`A_CNT0:  next_readdata = cnt_vis[0];
			`A_CNT0 + 8'h04: next_readdata = cnt_vis[1];
			`A_CNT0 + 8'h08: next_readdata = cnt_vis[2];
			`A_CNT0 + 8'h0c: next_readdata = cnt_vis[3];
			`A_DHI:   next_readdata = {16'h0, drift_high_count};
			`A_DLO:   next_readdata = {16'h0, drift_low_count};
			default:  next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack      <= 1'b0;
			readdata <= 32'h0000_0000;
		end
		else
		begin
			ack      <= req & ~ack;
			readdata <= (read & ~ack) ? next_readdata : readdata;
		end
	end

	// parameter registers; software settings survive the error loop
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			task_flags          <= `FLAGS_RST;
			test_selector       <= 16'h0000;
			rc_mode             <= 1'b0;
			reset_hold_interval <= `HOLD_RST;
			slope_value         <= 16'h0000;
			slope_step_fraction <= `SFRAC_RST;
			yellow_threshold    <= `YEL_RST;
			red_threshold       <= `RED_RST;
			preset_type         <= 16'h0000;
			preset_length       <= 32'h0000_0000;
		end
		else if (wr_fire)
		begin
			unique case (address)
				`A_FLAGS: task_flags <= wd & `FLAGS_MASK;
				`A_TEST:  test_selector <= wd;
				`A_CTRL:  rc_mode <= wd[2];
				`A_HOLD:  reset_hold_interval <= wd;
				`A_SLOPEV: slope_value <= wd;
				`A_SFRAC: slope_step_fraction <= wd;
				`A_YEL:   yellow_threshold <= wd;
				`A_RED:   red_threshold <= wd;
				`A_PTYPE: preset_type <= wd;
				`A_PLEN:  preset_length <= writedata;
				default:  ;
			endcase
		end
	end

	// jumper passes three flops; a change counts once two agree
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			jmp_sync      <= 3'h0;
			jumper_offset <= 1'b0;
		end
		else
		begin
			jmp_sync      <= {jmp_sync[1:0], offset_jumper};
			jumper_offset <= (jmp_sync[1] == jmp_sync[2]) ? jmp_sync[2] : jumper_offset;
		end
	end

	// run and error state; a new error wins over a clear
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state         <= run_ctl_pkg::st_idle;
			error_code    <= `ERR_NONE;
			special_start <= 1'b0;
			special_code  <= 16'h0000;
		end
		else
		begin
			special_start <= start_spec;
			special_code  <= start_spec ? test_selector : special_code;
			if (err_fire)
			begin
				state      <= run_ctl_pkg::st_error;
				error_code <= err_new;
			end
			else if (err_now)
			begin
				if (err_clear)
				begin
					state      <= run_ctl_pkg::st_idle;
					error_code <= `ERR_NONE;
				end
			end
			else if (start_norm)
				state <= run_ctl_pkg::st_run;
			else if (start_spec)
				state <= run_ctl_pkg::st_special;
			else if (running && (stop_req || (tick && preset_hit)))
				state <= run_ctl_pkg::st_idle;
			else if (state == run_ctl_pkg::st_special && (special_done || stop_req))
				state <= run_ctl_pkg::st_idle;
		end
	end

	// housekeeping tick
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b0;
		end
		else
		begin
			tick     <= tick_cnt == 16'(TICK_CYCLES - 1);
			tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
		end
	end

	// run statistics: counted live, published on each tick of a run
	for (genvar i = 0; i < 4; i++)
	begin : g_cnt
		always_ff @(posedge clock or negedge arst_n)
		begin
			if (!arst_n)
			begin
				cnt_raw[i] <= 32'h0000_0000;
				cnt_vis[i] <= 32'h0000_0000;
			end
			else if (start_norm)
			begin
				cnt_raw[i] <= 32'h0000_0000;
				cnt_vis[i] <= 32'h0000_0000;
			end
			else
			begin
				cnt_raw[i] <= cnt_raw[i] + {31'h0, cnt_inc[i]};
				cnt_vis[i] <= (tick & running) ? cnt_raw[i] : cnt_vis[i];
			end
		end
	end

	// rate led; a flash lasts until the next tick
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			led_green <= 1'b0;
			led_red   <= 1'b0;
		end
		else if (tick)
		begin
			led_green <= (running & ~ratio_red) | oor_reset;
			led_red   <= running & ~ratio_green;
		end
		else if (oor_reset)
			led_green <= 1'b1;
	end

	// range handling: drift steps back, reset holds at mid range
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstate    <= run_ctl_pkg::rg_track;
			dac       <= '{tracking_dac: `DAC_MID, slope_dac_a: 16'h0000, offset_dac_b: `DAC_MID};
			hold_left <= 16'h0000;
			unit_cnt  <= 3'h0;
			balance   <= 16'sh0000;
			drift_high_count <= 16'h0000;
			drift_low_count  <= 16'h0000;
		end
		else
		begin
			if (oor_reset)
			begin
				rstate           <= run_ctl_pkg::rg_hold;
				dac.tracking_dac <= `DAC_MID;
				hold_left        <= reset_hold_interval;
				unit_cnt         <= 3'h0;
			end
			else if (rstate == run_ctl_pkg::rg_hold)
			begin
				unit_cnt  <= (unit_cnt == 3'(HOLD_CYC - 1)) ? 3'h0 : unit_cnt + 3'h1;
				if (unit_cnt == 3'(HOLD_CYC - 1) && !hold_done)
					hold_left <= hold_left - 16'h0001;
				if (hold_done || err_now)
					rstate <= run_ctl_pkg::rg_track;
			end
			else if (oor_drift && range_high)
			begin
				dac.tracking_dac <= dac.tracking_dac - `TRACK_STEP;
				drift_high_count <= drift_high_count + 16'h0001;
			end
			else if (oor_drift)
			begin
				dac.tracking_dac <= dac.tracking_dac + `TRACK_STEP;
				drift_low_count  <= drift_low_count + 16'h0001;
			end
			// drift balance feeds the slope trim at each tick
			// a drift in the tick cycle opens the next count instead of being lost
			if (oor_drift && !rc_mode)
				balance <= (tick ? 16'sh0000 : balance)
					+ (range_high ? 16'sh0001 : 16'shffff);
			else if (tick)
				balance <= 16'sh0000;
			if (wr_sdac)
				dac.slope_dac_a <= wd;
			else if (trim_ok && !rc_mode && balance > 16'sh0000)
				dac.slope_dac_a <= dac.slope_dac_a - slope_step;
			else if (trim_ok && !rc_mode && balance < 16'sh0000)
				dac.slope_dac_a <= dac.slope_dac_a + slope_step;
			// offset nudged the other way to each drift in rc mode with rate tracking on
			if (wr_odac)
				dac.offset_dac_b <= wd;
			else if (oor_drift && rc_mode && task_flags[1])
				dac.offset_dac_b <= range_high ? dac.offset_dac_b - `OFF_STEP
					: dac.offset_dac_b + `OFF_STEP;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_reset_hold_entry: assert property (oor_reset |=> hold_mid && dac.tracking_dac == `DAC_MID)
		else $error("reset did not start hold");
	a_drift_step_back: assert property (oor_drift && range_high |=>
		dac.tracking_dac == $past(dac.tracking_dac) - `TRACK_STEP)
		else $error("drift high did not step tracking dac");
	a_tick_spacing: assert property (tick |=> !tick [*8])
		else $error("ticks too close");
	a_stats_frozen: assert property (!running && !start_norm |=> $stable(cnt_vis[0]))
		else $error("statistics changed outside run");
	a_error_entry: assert property (err_fire |=> status_led_red && error_code == $past(err_new))
		else $error("error not latched");
	a_error_exit: assert property (err_now && err_clear |=> idle_now && !status_led_red)
		else $error("error loop not left");
	a_preset_stop: assert property (running && tick && preset_hit && !err_fire |=> idle_now)
		else $error("fixed run did not end");
	a_setup_error: assert property (start_req && setup_bad && !comm_error |=>
		error_code == `ERR_SETUP)
		else $error("jumper setup error missed");
	a_slope_disabled: assert property (!task_flags[1] && !wr_sdac |=> $stable(dac.slope_dac_a))
		else $error("slope moved with tracking off");
	a_special_start: assert property (start_spec |=> special_start && special_code == test_selector)
		else $error("special task not started");
endmodule // acquisition_run_controller

// File: run_ctl_consts.svh
// constants of the acquisition run controller
// assumes a 20 MHz clock and a byte-addressed register bus
`ifndef RUN_CTL_CONSTS_SVH
`define RUN_CTL_CONSTS_SVH
`define CLK_MHZ 20
`define CLK_NS 50
`define TICK_US 500
`define HOLD_UNIT_NS 250
`define HOLD_UNIT_CYC 3'h5
`define A_FLAGS 8'h00
`define A_ERROR 8'h04
`define A_TEST 8'h08
`define A_CTRL 8'h0c
`define A_STAT 8'h10
`define A_HOLD 8'h14
`define A_SLOPEV 8'h18
`define A_SFRAC 8'h1c
`define A_YEL 8'h20
`define A_RED 8'h24
`define A_PTYPE 8'h28
`define A_PLEN 8'h2c
`define A_TDAC 8'h30
`define A_SDAC 8'h34
`define A_ODAC 8'h38
`define A_CNT0 8'h3c
`define A_DHI 8'h4c
`define A_DLO 8'h50
`define FLAGS_RST 16'h006a
`define FLAGS_MASK 16'h07fe
`define SFRAC_RST 16'h0ccd
`define YEL_RST 16'h4000
`define RED_RST 16'h2f17
`define HOLD_RST 16'h0028
`define DAC_MID 16'h8000
`define TRACK_STEP 16'h0100
`define OFF_STEP 16'h0040
`define ERR_NONE 16'h0000
`define ERR_COMM 16'h0001
`define ERR_SETUP 16'h0002
`define ERR_TCAL 16'h0006
`endif

// File: run_ctl_pkg.sv
// types shared by the acquisition run controller
// encodings given as literals here, not taken from run_ctl_consts.svh
package run_ctl_pkg;
	typedef enum logic [3:0] {
		st_idle    = 4'h1,
		st_run     = 4'h2,
		st_special = 4'h4,
		st_error   = 4'h8
	} run_state_t;
	typedef enum logic [1:0] {
		rg_track = 2'h1,
		rg_hold  = 2'h2
	} range_state_t;
	typedef struct packed {
		logic rate_track;
		logic fir_average;
		logic base_acquire;
		logic thr_adjust;
		logic shift_correct;
		logic resid_correct;
		logic hist_freeze;
		logic hist_delta;
		logic base_cut;
	} task_ctl_t;
	typedef struct packed {
		logic [15:0] tracking_dac;
		logic [15:0] slope_dac_a;
		logic [15:0] offset_dac_b;
	} dac_out_t;
endpackage

// File: filter_model.sv
// behavioural model of the pulse-filter logic facing the run controller
// assumes the bench calls its tasks and shares the controller clock
`timescale 1ns/1ps
module filter_model (
	// clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// from the controller
	input  wire logic special_start,
	// to the controller
	output logic      out_of_range,
	output logic      range_high,
	output logic      is_reset,
	output logic      event_out,
	output logic      event_in,
	output logic      live,
	output logic      comm_error,
	output logic      trackcal_error,
	output logic      special_done
);
	logic in_on = 1'b0;
	logic out_on = 1'b0;
	int   done_wait = 3;
	int   done_cnt = 0;
	initial
	begin
		{out_of_range, range_high, is_reset, comm_error, trackcal_error} = '0;
		{event_out, event_in, live, special_done} = '0;
	end
	always @(posedge clock)
	begin
		event_in <= in_on;
		event_out <= in_on & out_on;
		live <= in_on;
	end
	// wait is slow or prompt, as the bench asks
	always @(posedge clock)
	begin
		special_done <= (done_cnt == 1);
		if (!arst_n)
			done_cnt <= 0;
		else if (special_start)
			done_cnt <= done_wait;
		else if (done_cnt != 0)
			done_cnt <= done_cnt - 1;
	end
	task set_rate(input logic i, input logic o, input int w);
		in_on <= i;
		out_on <= o;
		done_wait <= w;
	endtask
	task range_pulse(input logic hi, input logic rst);
		@(posedge clock);
		out_of_range <= 1'b1;
		range_high <= hi;
		is_reset <= rst;
		@(posedge clock);
		out_of_range <= 1'b0;
		is_reset <= 1'b0;
	endtask
	task err_pulse(input logic tcal);
		@(posedge clock);
		comm_error <= !tcal;
		trackcal_error <= tcal;
		@(posedge clock);
		comm_error <= 1'b0;
		trackcal_error <= 1'b0;
	endtask
endmodule // filter_model

// File: tb.sv
// self-checking bench of the acquisition run controller
// assumes filter_model.sv and a 64-cycle housekeeping tick
`timescale 1ns/1ps
`include "run_ctl_consts.svh"
module tb;
	localparam int TICK = 64;
	logic                   clock = 1'b0;
	logic                   arst_n = 1'b0;
	logic [7:0]             address = 8'h00;
	logic                   read = 1'b0;
	logic                   write = 1'b0;
	logic [31:0]            writedata = 32'h0;
	logic                   offset_jumper = 1'b0;
	logic [31:0]            readdata;
	logic                   waitrequest;
	logic                   out_of_range, range_high, is_reset, event_out, event_in, live;
	logic                   comm_error, trackcal_error, special_done;
	run_ctl_pkg::task_ctl_t task_ctl;
	run_ctl_pkg::dac_out_t  dac;
	logic                   hold_mid, running, special_start;
	logic                   led_green, led_red, status_led_red;
	logic [15:0]            special_code;
	logic [31:0]            rd, v;
	logic [15:0]            good_sel [13] = '{0, 1, 2, 3, 4, 6, 8, 11, 12, 13, 14, 15, 16};
	logic [15:0]            bad_sel [5] = '{5, 7, 9, 10, 17};
	int                     error_cnt = 0;
	int                     checked = 0;
	int                     cyc = 0;
	int                     n, i;

	acquisition_run_controller #(.TICK_CYCLES(TICK)) uut (.clock(clock), .arst_n(arst_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .out_of_range(out_of_range),
		.range_high(range_high), .is_reset(is_reset), .event_out(event_out),
		.event_in(event_in), .live(live), .comm_error(comm_error),
		.trackcal_error(trackcal_error), .special_done(special_done),
		.offset_jumper(offset_jumper), .task_ctl(task_ctl), .dac(dac), .hold_mid(hold_mid),
		.running(running), .special_start(special_start), .special_code(special_code),
		.led_green(led_green), .led_red(led_red), .status_led_red(status_led_red));
	filter_model fm (.clock(clock), .arst_n(arst_n), .special_start(special_start),
		.out_of_range(out_of_range), .range_high(range_high), .is_reset(is_reset),
		.event_out(event_out), .event_in(event_in), .live(live), .comm_error(comm_error),
		.trackcal_error(trackcal_error), .special_done(special_done));

	always #25 clock = ~clock;
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			final_report();
		end
	end

	task final_report;
		$display("mismatches %0d of %0d checks", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task chk1(input logic s, input logic e);
		chk({31'h0, s}, {31'h0, e});
	endtask
	// request held until the rising edge that samples waitrequest low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task wait_n(input int c);
		repeat (c) @(negedge clock);
	endtask

	initial
	begin
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		rdc(`A_FLAGS, 32'h006a);
		chk({23'h0, task_ctl}, 32'h158);
		chk({16'h0, dac.tracking_dac}, 32'h8000);
		rdc(`A_HOLD, 32'h0028);
		rdc(`A_SFRAC, 32'h0ccd);
		rdc(`A_YEL, 32'h4000);
		rdc(`A_RED, 32'h2f17);
		rdc(`A_ERROR, 32'h0);
		rdc(8'h7c, 32'h0);
		for (i = 0; i < 16; i++)
		begin
			v = 32'h1 << i;
			wr(`A_FLAGS, v);
			rdc(`A_FLAGS, v & 32'h07fe);
			chk({23'h0, task_ctl}, {23'h0, v[1], v[2], v[3], v[4], v[5], v[6], v[7], v[9], v[10]});
		end
		// drifts with rate tracking off leave the slope alone
		wr(`A_SLOPEV, 32'h1000);
		wr(`A_FLAGS, 32'h0068);
		fm.range_pulse(1'b1, 1'b0);
		@(negedge clock);
		chk({16'h0, dac.tracking_dac}, 32'h7f00);
		rdc(`A_DHI, 32'h1);
		repeat (3) fm.range_pulse(1'b0, 1'b0);
		@(negedge clock);
		chk({16'h0, dac.tracking_dac}, 32'h8200);
		rdc(`A_DLO, 32'h3);
		wait_n(TICK + 8);
		rdc(`A_SDAC, 32'h0);
		wr(`A_FLAGS, 32'h006a);
		fm.range_pulse(1'b0, 1'b0);
		wait_n(TICK + 8);
		rdc(`A_SDAC, 32'h00cc);
		fm.range_pulse(1'b1, 1'b0);
		wait_n(TICK + 8);
		rdc(`A_SDAC, 32'h0);
		// reset hold of 4 units, a drift inside it is dropped
		wr(`A_HOLD, 32'h4);
		fm.range_pulse(1'b0, 1'b1);
		@(negedge clock);
		chk1(hold_mid, 1'b1);
		chk({16'h0, dac.tracking_dac}, 32'h8000);
		chk1(led_green, 1'b1);
		fm.range_pulse(1'b1, 1'b0);
		wait_n(12);
		chk1(hold_mid, 1'b1);
		wait_n(12);
		chk1(hold_mid, 1'b0);
		chk({16'h0, dac.tracking_dac}, 32'h8000);
		rdc(`A_DHI, 32'h2);
		wr(`A_CTRL, 32'h4);
		rdc(`A_CTRL, 32'h4);
		fm.range_pulse(1'b1, 1'b0);
		@(negedge clock);
		chk({16'h0, dac.offset_dac_b}, 32'h7fc0);
		wr(`A_FLAGS, 32'h0068);
		fm.range_pulse(1'b1, 1'b0);
		@(negedge clock);
		chk({16'h0, dac.offset_dac_b}, 32'h7fc0);
		wr(`A_FLAGS, 32'h006a);
		wr(`A_CTRL, 32'h0);
		// normal run: full throughput, then none
		fm.set_rate(1'b1, 1'b1, 3);
		wr(`A_PTYPE, 32'h0);
		wr(`A_CTRL, 32'h1);
		rdc(`A_STAT, 32'h11);
		wait_n(2 * TICK + 8);
		chk({30'h0, led_green, led_red}, 32'h2);
		fm.set_rate(1'b1, 1'b0, 3);
		wait_n(3 * TICK + 24);
		chk({30'h0, led_green, led_red}, 32'h3);
		wait_n(3 * TICK);
		chk({30'h0, led_green, led_red}, 32'h1);
		wr(`A_CTRL, 32'h2);
		bus(1'b0, `A_CNT0, 32'h0);
		v = rd;
		chk1(v == 32'h0, 1'b0);
		wait_n(TICK + 8);
		rdc(`A_CNT0, v);
		chk({30'h0, led_green, led_red}, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		rdc(8'h44, rd);
		// every preset type ends a 100-count run at a tick
		fm.set_rate(1'b1, 1'b1, 3);
		wr(`A_PLEN, 32'd100);
		for (i = 1; i < 5; i++)
		begin
			wr(`A_PTYPE, i);
			wr(`A_CTRL, 32'h1);
			@(negedge clock);
			n = 0;
			while (running === 1'b1 && n < 400)
			begin
				@(negedge clock);
				n++;
			end
			chk1(n > 80 && n < 240, 1'b1);
		end
		wr(`A_PTYPE, 32'h0);
		wr(`A_FLAGS, 32'h016a);
		foreach (good_sel[i])
		begin
			fm.set_rate(1'b1, 1'b1, (i == 0) ? 3 : 30);
			wr(`A_TEST, {16'h0, good_sel[i]});
			wr(`A_CTRL, 32'h1);
			n = 0;
			while (special_start !== 1'b1 && n < 10)
			begin
				@(negedge clock);
				n++;
			end
			chk({15'h0, special_start, special_code}, {15'h0, 1'b1, good_sel[i]});
			wait_n(40);
			rdc(`A_STAT, 32'h10);
		end
		foreach (bad_sel[i])
		begin
			wr(`A_TEST, {16'h0, bad_sel[i]});
			wr(`A_CTRL, 32'h1);
			rdc(`A_STAT, 32'h0);
		end
		wr(`A_TEST, 32'h0);
		wr(`A_FLAGS, 32'h006a);
		// fault sources, clearing restores the loop exit
		for (i = 0; i < 2; i++)
		begin
			fm.err_pulse(i[0]);
			wait_n(2);
			chk1(status_led_red, 1'b1);
			v = (i == 0) ? 32'h1 : 32'h6;
			rdc(`A_ERROR, v);
			wr(`A_ERROR, 32'h3);
			rdc(`A_ERROR, v);
			wr(`A_ERROR, 32'h0);
			rdc(`A_ERROR, 32'h0);
			chk1(status_led_red, 1'b0);
			rdc(`A_HOLD, 32'h4);
		end
		offset_jumper <= 1'b1;
		wait_n(4);
		wr(`A_CTRL, 32'h1);
		wait_n(2);
		chk1(status_led_red, 1'b1);
		rdc(`A_ERROR, 32'h2);
		offset_jumper <= 1'b0;
		wr(`A_ERROR, 32'h0);
		rdc(`A_STAT, 32'h10);
		final_report();
	end
endmodule // tb
